// ==== logic/pmc_pkg.sv ====
/*
  shared constants and types for the power mode controller.
  assumes a 100 MHz system clock and a byte-addressed register bus.
*/
`default_nettype none

package pmc_pkg;

  // register byte offsets
  localparam logic [3:0] PMC_CTRL_OFS = 4'h0;
  localparam logic [3:0] PMC_STAT_OFS = 4'h4;
  localparam logic [3:0] PMC_ACK_OFS = 4'h8;

  // status and acknowledge field positions
  localparam int PMC_ST_FLAG_BIT = 0;
  localparam int PMC_ST_LATCH_BIT = 1;
  localparam int PMC_ST_MODE_LSB = 4;
  localparam int PMC_ACK_BIT = 0;

  // control word, low bit first: permit, deep, partial, lvd on,
  // lvd in stop, debug entry enable, oscillator kept, rate[2:0]
  typedef struct packed {
    logic [2:0] rate;
    logic osc_keep;
    logic dbg_en;
    logic lvd_stop;
    logic lvd_on;
    logic partial;
    logic deep;
    logic permit;
  } pmc_ctrl_t;

  localparam int PMC_CTRL_W = 10;
  localparam pmc_ctrl_t PMC_CTRL_RST = 10'h000;

  typedef enum logic [2:0] {
    PMC_BOOT, PMC_RUN, PMC_WAIT, PMC_HALT,
    PMC_STOP1, PMC_STOP2, PMC_STOP3
  } pmc_state_t;

  // debug command codes
  localparam logic [2:0] PMC_CMD_MEM = 3'h0;
  localparam logic [2:0] PMC_CMD_MEMST = 3'h1;
  localparam logic [2:0] PMC_CMD_DREG = 3'h2;
  localparam logic [2:0] PMC_CMD_HALT = 3'h3;
  localparam logic [2:0] PMC_CMD_CPUREG = 3'h4;
  localparam logic [2:0] PMC_CMD_TRACE = 3'h5;
  localparam logic [2:0] PMC_CMD_GO = 3'h6;

  // interrupt vector selection on a stop3 exit
  localparam logic [1:0] PMC_VEC_IRQ = 2'h0;
  localparam logic [1:0] PMC_VEC_KBI = 2'h1;
  localparam logic [1:0] PMC_VEC_RTI = 2'h2;

  // cycles after reset release before the mode pin is read
  localparam logic [1:0] PMC_BOOT_CYC = 2'h3;

  // self-clocked wake source: one tick per period
  localparam int PMC_CLK_NS = 10;
  localparam int PMC_TICK_NS = 1000000;
  localparam int PMC_TICK_CYC = PMC_TICK_NS / PMC_CLK_NS;

  // base of the wake interval in ticks, shifted by the rate
  localparam logic [9:0] PMC_WAKE_BASE = 10'h004;

endpackage

`default_nettype wire

// ==== logic/pmc_sync.sv ====
/*
  two-stage synchroniser for pin inputs, any width.
  assumes the inputs are asynchronous to clk.
*/
`timescale 1ns/1ns
`default_nettype none

module pmc_sync
  import pmc_pkg::*;
#(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '1
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } pmc_sync_t;

  pmc_sync_t s;
  pmc_sync_t next_s;

  // the first stage feeds only the second stage
  always_comb
  begin
    next_s.meta = d;
    next_s.sync = s.meta;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s.meta <= RST_VAL;
      s.sync <= RST_VAL;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign q = s.sync;

endmodule

`default_nettype wire

// ==== logic/pmc_mode_ctrl.sv ====
/*
  power and debug mode controller: run, wait, debug halt, stop1-3,
  pin latch hold with recovery flag, self-clocked periodic wake.
  assumes core strobes are one-cycle pulses on clk, pins asynchronous.
*/
// The Avalon-MM slave port and the register offsets were chosen for this implementation.
// How it works
// - halt entry: mode pin low at reset, halt command, instruction, breakpoints.
// - in debug halt the processor is suspended and runs only trace steps.
// - memory, status, debug register and halt commands taken in run and halt.
// - cpu register, trace and resume commands only taken in debug halt.
// - wait instruction stops the processor clock and clears interrupt mask.
// - interrupt in wait resumes with the stacking sequence.
// - in wait only halt and status commands; status returns error, no access.
// - halt command in wait goes straight to debug halt.
// - permitted stop instruction enters a stop level and halts clocks.
// - stop instruction without permit forces an illegal opcode reset.
// - deep and partial bits pick stop2, stop1 or stop3.
// - stop1 and stop2 only when the low voltage detector is not armed.
// - stop1 wakes on reset pin or interrupt pin, taken as active low.
// - stop1 wake restarts as from power-on, registers lost.
// - stop2 latches pins, keeps ram, holds until acknowledge is written.
// - stop2 wakes on reset pin, interrupt pin or periodic wake.
// - stop2 wake restarts as power-on except pins stay latched.
// - recovery flag set after stop2 wake until acknowledge is written.
// - opened latches follow port registers; software restores first.
// - stop3 halts clocks, optional oscillator, keeps all state.
// - stop3 reset pin exit resets; interrupt exits take their vector.
// - self-clocked source drives periodic wake; rate zero disables both.
// - stop1 or stop2 with detector armed or debug enabled gives stop3.
`timescale 1ns/1ns
`default_nettype none

module pmc_mode_ctrl
  import pmc_pkg::*;
#(
  parameter int TICK_CYCLES = PMC_TICK_CYC,
  parameter int KP_W = 8
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic wait_instr,
  input wire logic stop_instr,
  input wire logic debug_halt_instruction,
  input wire logic serial_debug_controller_bkpt,
  input wire logic onchip_breakpoint_unit_bkpt,
  input wire logic irq_request,
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_code,
  input wire logic debug_pin_mode_select,
  input wire logic reset_pin_n,
  input wire logic wake_irq_pin_n,
  input wire logic [KP_W-1:0] keypad_interrupt_pins_n,
  output logic cpu_clock_en,
  output logic cpu_suspended,
  output logic cpu_step,
  output logic imask_clear,
  output logic stack_start,
  output logic cmd_ack,
  output logic cmd_err,
  output logic cmd_rej,
  output logic illegal_opcode_reset,
  output logic por_restart,
  output logic vector_take,
  output logic [1:0] vector_sel,
  output logic clocks_halted,
  output logic osc_run,
  output logic ram_powered,
  output logic pin_latch_hold,
  output logic periodic_wake_on,
  output logic [2:0] mode_code
);

  localparam int TW = $clog2(TICK_CYCLES);

  if (TICK_CYCLES < 2)
  begin : g_chk_tick
    $error("TICK_CYCLES must be at least 2");
  end
  if (KP_W < 1)
  begin : g_chk_kp
    $error("KP_W must be at least 1");
  end

  typedef struct packed {
    pmc_state_t state;
    pmc_ctrl_t ctrl;
    logic [1:0] boot_cnt;
    logic flag;
    logic latch;
    logic [TW-1:0] tick_cnt;
    logic [9:0] wake_cnt;
    logic periodic_wake_interrupt;
    logic waitreq;
    logic [31:0] rdata;
    logic cpu_clk;
    logic susp;
    logic step;
    logic imask;
    logic stack;
    logic ack;
    logic err;
    logic rej;
    logic ill;
    logic por;
    logic vec;
    logic [1:0] vsel;
    logic halted;
    logic osc;
    logic ram;
    logic pwo;
  } pmc_regs_t;

  pmc_regs_t s;
  pmc_regs_t next_s;

  logic ms_s;
  logic rstp_s;
  logic irqp_s;
  logic [KP_W-1:0] kbi_s;

  // all pins pass two flops before use
  pmc_sync #(.W(3), .RST_VAL(3'h7)) u_sync_pins (
    .clk(clk),
    .rst(rst),
    .d({debug_pin_mode_select, reset_pin_n, wake_irq_pin_n}),
    .q({ms_s, rstp_s, irqp_s})
  );

  pmc_sync #(.W(KP_W), .RST_VAL({KP_W{1'b1}})) u_sync_kbi (
    .clk(clk),
    .rst(rst),
    .d(keypad_interrupt_pins_n),
    .q(kbi_s)
  );

  logic rst_wake;
  logic irq_wake;
  logic kbi_wake;
  logic lvd_armed;
  logic dbg_trig;
  logic halt_cmd;
  logic bus_req;
  logic bus_done;
  logic ack_wr;
  logic [9:0] wake_ticks;
  pmc_state_t stop_level;

  // wake pins are active low whatever their run-mode setup
  assign rst_wake = ~rstp_s;
  assign irq_wake = ~irqp_s;
  assign kbi_wake = ~&kbi_s;
  assign lvd_armed = s.ctrl.lvd_on & s.ctrl.lvd_stop;
  assign halt_cmd = cmd_valid & (cmd_code == PMC_CMD_HALT);
  assign dbg_trig = debug_halt_instruction | serial_debug_controller_bkpt |
                    onchip_breakpoint_unit_bkpt | halt_cmd;
  assign bus_req = avs_read | avs_write;
  assign bus_done = bus_req & ~s.waitreq;
  assign ack_wr = bus_done & avs_write & (avs_address == PMC_ACK_OFS) &
                  avs_writedata[PMC_ACK_BIT];
  assign wake_ticks = PMC_WAKE_BASE << s.ctrl.rate;

  // level choice; armed detector or debug enable forces stop3
  always_comb
  begin
    if (!s.ctrl.deep || lvd_armed || s.ctrl.dbg_en)
      stop_level = PMC_STOP3;
    else if (s.ctrl.partial)
      stop_level = PMC_STOP2;
    else
      stop_level = PMC_STOP1;
  end

  always_comb
  begin
    next_s = s;
    next_s.step = 1'b0;
    next_s.imask = 1'b0;
    next_s.stack = 1'b0;
    next_s.ack = 1'b0;
    next_s.err = 1'b0;
    next_s.rej = 1'b0;
    next_s.ill = 1'b0;
    next_s.por = 1'b0;
    next_s.vec = 1'b0;
    next_s.periodic_wake_interrupt = 1'b0;

    // one wait cycle per access keeps read data on a flop
    next_s.waitreq = ~(bus_req & s.waitreq);
    if (bus_req && s.waitreq)
    begin
      next_s.rdata = 32'h0000_0000;
      unique case (avs_address)
        PMC_CTRL_OFS: next_s.rdata[PMC_CTRL_W-1:0] = s.ctrl;
        PMC_STAT_OFS:
        begin
          next_s.rdata[PMC_ST_FLAG_BIT] = s.flag;
          next_s.rdata[PMC_ST_LATCH_BIT] = s.latch;
          next_s.rdata[PMC_ST_MODE_LSB +: 3] = s.state;
        end
        default: next_s.rdata = 32'h0000_0000;
      endcase
    end
    if (bus_done && avs_write && avs_address == PMC_CTRL_OFS)
      next_s.ctrl = pmc_ctrl_t'(avs_writedata[PMC_CTRL_W-1:0]);

    // acknowledge opens the latches and drops the flag
    if (ack_wr && s.state != PMC_STOP2)
    begin
      next_s.flag = 1'b0;
      next_s.latch = 1'b0;
    end

    // self-clocked source and periodic wake; rate zero stops both
    if (s.ctrl.rate == 3'h0)
    begin
      next_s.tick_cnt = '0;
      next_s.wake_cnt = 10'h000;
    end
    else if (s.tick_cnt == TW'(TICK_CYCLES - 1))
    begin
      next_s.tick_cnt = '0;
      if (s.wake_cnt >= wake_ticks - 10'h001)
      begin
        next_s.wake_cnt = 10'h000;
        next_s.periodic_wake_interrupt = 1'b1;
      end
      else
      begin
        next_s.wake_cnt = s.wake_cnt + 10'h001;
      end
    end
    else
    begin
      next_s.tick_cnt = s.tick_cnt + TW'(1);
    end

    // debug command answers; halt entry is handled per state
    if (cmd_valid)
    begin
      unique case (s.state)
        PMC_RUN, PMC_HALT:
        begin
          if (cmd_code <= PMC_CMD_HALT || s.state == PMC_HALT)
            next_s.ack = (cmd_code <= PMC_CMD_GO);
          next_s.rej = ~next_s.ack;
        end
        PMC_WAIT, PMC_STOP3:
        begin
          // status commands report stop or wait with no memory access
          next_s.err = (cmd_code == PMC_CMD_MEMST);
          next_s.ack = halt_cmd && (s.state == PMC_WAIT || s.ctrl.dbg_en);
          next_s.rej = ~next_s.err & ~next_s.ack;
        end
        default: next_s.rej = 1'b1;
      endcase
    end

    unique case (s.state)
      PMC_BOOT:
      begin
        // give the pin synchroniser time to show the real level
        if (s.boot_cnt == PMC_BOOT_CYC)
          next_s.state = ms_s ? PMC_RUN : PMC_HALT;
        else
          next_s.boot_cnt = s.boot_cnt + 2'h1;
      end
      PMC_RUN:
      begin
        if (dbg_trig)
          next_s.state = PMC_HALT;
        else if (stop_instr && !s.ctrl.permit)
          next_s.ill = 1'b1;
        else if (stop_instr)
        begin
          next_s.state = stop_level;
          next_s.latch = (stop_level == PMC_STOP2) | s.latch;
        end
        else if (wait_instr)
        begin
          next_s.state = PMC_WAIT;
          next_s.imask = 1'b1;
        end
      end
      PMC_WAIT:
      begin
        if (halt_cmd)
          next_s.state = PMC_HALT;
        else if (irq_request)
        begin
          next_s.state = PMC_RUN;
          next_s.stack = 1'b1;
        end
      end
      PMC_HALT:
      begin
        // suspended until the resume command; trace runs one step
        if (cmd_valid && cmd_code == PMC_CMD_GO)
          next_s.state = PMC_RUN;
        else if (cmd_valid && cmd_code == PMC_CMD_TRACE)
          next_s.step = 1'b1;
      end
      PMC_STOP1:
      begin
        if (rst_wake || irq_wake)
        begin
          next_s.state = PMC_BOOT;
          next_s.por = 1'b1;
        end
      end
      PMC_STOP2:
      begin
        if (rst_wake || irq_wake || s.periodic_wake_interrupt)
        begin
          next_s.state = PMC_BOOT;
          next_s.por = 1'b1;
          next_s.flag = 1'b1;
        end
      end
      PMC_STOP3:
      begin
        if (rst_wake)
        begin
          next_s.state = PMC_BOOT;
          next_s.por = 1'b1;
        end
        else if (halt_cmd && s.ctrl.dbg_en)
          next_s.state = PMC_HALT;
        else if (irq_wake || kbi_wake || s.periodic_wake_interrupt)
        begin
          next_s.state = PMC_RUN;
          next_s.vec = 1'b1;
          next_s.vsel = irq_wake ? PMC_VEC_IRQ :
                        kbi_wake ? PMC_VEC_KBI : PMC_VEC_RTI;
        end
      end
    endcase

    // a power-on style restart loses the control register
    if (next_s.por)
    begin
      next_s.ctrl = PMC_CTRL_RST;
      next_s.boot_cnt = 2'h0;
    end

    // flop copies of the mode outputs
    next_s.cpu_clk = (next_s.state == PMC_RUN);
    next_s.susp = (next_s.state == PMC_HALT);
    next_s.halted = (next_s.state >= PMC_STOP1);
    next_s.osc = (next_s.state == PMC_STOP3) & next_s.ctrl.osc_keep;
    next_s.ram = (next_s.state != PMC_STOP1);
    next_s.pwo = (next_s.ctrl.rate != 3'h0);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s <= '0;
      s.waitreq <= 1'b1;
      s.ram <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign avs_readdata = s.rdata;
  assign avs_waitrequest = s.waitreq;
  assign cpu_clock_en = s.cpu_clk;
  assign cpu_suspended = s.susp;
  assign cpu_step = s.step;
  assign imask_clear = s.imask;
  assign stack_start = s.stack;
  assign cmd_ack = s.ack;
  assign cmd_err = s.err;
  assign cmd_rej = s.rej;
  assign illegal_opcode_reset = s.ill;
  assign por_restart = s.por;
  assign vector_take = s.vec;
  assign vector_sel = s.vsel;
  assign clocks_halted = s.halted;
  assign osc_run = s.osc;
  assign ram_powered = s.ram;
  assign pin_latch_hold = s.latch;
  assign periodic_wake_on = s.pwo;
  assign mode_code = s.state;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  property p_stop_deny;
    s.state == PMC_RUN && !dbg_trig && stop_instr && !s.ctrl.permit
      |=> illegal_opcode_reset && mode_code == PMC_RUN;
  endproperty
  a_stop_deny: assert property (p_stop_deny)
    else $error("stop without permit did not force reset");

  property p_stop3_forced;
    s.state == PMC_RUN && !dbg_trig && stop_instr && s.ctrl.permit &&
      (lvd_armed || s.ctrl.dbg_en) |=> mode_code == PMC_STOP3;
  endproperty
  a_stop3_forced: assert property (p_stop3_forced)
    else $error("armed detector or debug did not force stop3");

  property p_stop_level;
    s.state == PMC_RUN && !dbg_trig && stop_instr && s.ctrl.permit &&
      s.ctrl.deep && !lvd_armed && !s.ctrl.dbg_en
      |=> mode_code == (s.ctrl.partial ? PMC_STOP2 : PMC_STOP1)
          && clocks_halted;
  endproperty
  a_stop_level: assert property (p_stop_level)
    else $error("wrong stop level chosen");

  property p_wait_entry;
    s.state == PMC_RUN && !dbg_trig && !stop_instr && wait_instr
      |=> imask_clear && !cpu_clock_en ##1 !imask_clear;
  endproperty
  a_wait_entry: assert property (p_wait_entry)
    else $error("wait entry did not stop clock and clear mask");

  property p_wait_irq;
    s.state == PMC_WAIT && !halt_cmd && irq_request
      |=> stack_start && cpu_clock_en;
  endproperty
  a_wait_irq: assert property (p_wait_irq)
    else $error("interrupt did not leave wait");

  property p_wait_halt;
    s.state == PMC_WAIT && halt_cmd |=> cpu_suspended && cmd_ack;
  endproperty
  a_wait_halt: assert property (p_wait_halt)
    else $error("halt command did not wake into debug halt");

  property p_halt_susp;
    cpu_suspended |-> !cpu_clock_en && mode_code == PMC_HALT;
  endproperty
  a_halt_susp: assert property (p_halt_susp)
    else $error("processor clocked in debug halt");

  property p_active_cmd;
    cmd_valid && cmd_code == PMC_CMD_CPUREG && s.state != PMC_HALT
      |=> cmd_rej && !cmd_ack;
  endproperty
  a_active_cmd: assert property (p_active_cmd)
    else $error("cpu register command taken outside debug halt");

  property p_flag_hold;
    s.flag && !ack_wr |=> s.flag && pin_latch_hold;
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("recovery flag lost before acknowledge");

  property p_stop2_wake;
    s.state == PMC_STOP2 && s.periodic_wake_interrupt |=> por_restart && s.flag;
  endproperty
  a_stop2_wake: assert property (p_stop2_wake)
    else $error("periodic wake did not end stop2");

  property p_rti_off;
    !periodic_wake_on |=> !s.periodic_wake_interrupt;
  endproperty
  a_rti_off: assert property (p_rti_off)
    else $error("periodic wake fired with rate zero");

endmodule

`default_nettype wire

// ==== tb/pmc_dbg_host.sv ====
/*
  debug host model: sends one command per call and returns the answer.
  assumes the controller answers exactly one cycle after the command.
*/
`timescale 1ns/1ns
`default_nettype none

module pmc_dbg_host
  import pmc_pkg::*;
(
  input wire logic clk,
  input wire logic cmd_ack,
  input wire logic cmd_err,
  input wire logic cmd_rej,
  output logic cmd_valid,
  output logic [2:0] cmd_code
);
  initial
  begin
    cmd_valid = 1'b0;
    cmd_code = 3'h7;
  end

  // one command held one cycle; the code is inverted afterwards so a
  // stale code never looks valid
  task automatic send(input logic [2:0] c, output logic [2:0] r);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_code <= ~c;
    @(negedge clk);
    r = {cmd_ack, cmd_err, cmd_rej};
  endtask
endmodule

`default_nettype wire

// ==== tb/pmc_mode_ctrl_bench.sv ====
/*
  bench for the power mode controller: registers, debug, wait, stops.
  assumes the debug host model and a 100 MHz clock; tick shortened to 8.
*/
`timescale 1ns/1ns
`default_nettype none

module pmc_mode_ctrl_bench;
  import pmc_pkg::*;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [4:0] core = 5'h00;
  logic irq_request = 1'b0;
  logic debug_pin_mode_select = 1'b1;
  logic reset_pin_n = 1'b1;
  logic wake_irq_pin_n = 1'b1;
  logic [7:0] keypad_interrupt_pins_n = 8'hff;
  logic cmd_valid, cmd_ack, cmd_err, cmd_rej, cpu_clock_en, cpu_suspended;
  logic cpu_step, imask_clear, stack_start, illegal_opcode_reset;
  logic por_restart, vector_take, clocks_halted, osc_run, ram_powered;
  logic pin_latch_hold, periodic_wake_on;
  logic [2:0] cmd_code, mode_code;
  logic [1:0] vector_sel;
  logic [31:0] s3_ctrl [3] = '{32'h1f, 32'h41, 32'h81};
  logic [1:0] s3_src [3] = '{PMC_VEC_KBI, PMC_VEC_IRQ, PMC_VEC_RTI};
  int fails = 0;
  int num_checks = 0;

  always #5 clk = ~clk;

  pmc_mode_ctrl #(.TICK_CYCLES(8), .KP_W(8)) pmc_mode_ctrl_inst (
    .clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .wait_instr(core[0]),
    .stop_instr(core[1]), .debug_halt_instruction(core[2]),
    .serial_debug_controller_bkpt(core[3]),
    .onchip_breakpoint_unit_bkpt(core[4]), .irq_request, .cmd_valid,
    .cmd_code, .debug_pin_mode_select, .reset_pin_n, .wake_irq_pin_n,
    .keypad_interrupt_pins_n, .cpu_clock_en, .cpu_suspended, .cpu_step,
    .imask_clear, .stack_start, .cmd_ack, .cmd_err, .cmd_rej,
    .illegal_opcode_reset, .por_restart, .vector_take, .vector_sel,
    .clocks_halted, .osc_run, .ram_powered, .pin_latch_hold,
    .periodic_wake_on, .mode_code
  );

  pmc_dbg_host pmc_dbg_host_inst (
    .clk, .cmd_ack, .cmd_err, .cmd_rej, .cmd_valid, .cmd_code
  );

  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk_mode(input pmc_state_t m);
    chk("mode", 32'(m), 32'(mode_code));
  endtask

  // one access; the request stays put until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a,
    input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= ~wr;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    if (n >= 20)
      chk("bus answer", 32'h0, 32'h1);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] unused;
    bus(1'b1, a, d, unused);
  endtask

  task automatic rdc(input logic [3:0] a, input logic [31:0] exp,
    input string what);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, d);
    chk(what, exp, d);
  endtask

  task automatic cmd(input logic [2:0] c, input logic [2:0] exp);
    logic [2:0] r;
    pmc_dbg_host_inst.send(c, r);
    chk("debug answer", 32'(exp), 32'(r));
  endtask

  // one-cycle core strobe, then look while the answer stands
  task automatic stb(input int i);
    @(posedge clk);
    core[i] <= 1'b1;
    @(posedge clk);
    core[i] <= 1'b0;
    @(negedge clk);
  endtask

  task automatic do_reset(input logic pin);
    @(posedge clk);
    debug_pin_mode_select <= pin;
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    @(negedge clk);
    chk("reset outputs", 32'h0c, {25'h0, mode_code, avs_waitrequest,
      ram_powered, cpu_clock_en, clocks_halted});
    @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(negedge clk);
  endtask

  task automatic enter(input logic [31:0] ctrl, input pmc_state_t m);
    wr(PMC_CTRL_OFS, ctrl);
    stb(1);
    chk_mode(m);
    chk("clocks halted", 32'h1, 32'(clocks_halted));
  endtask

  // drive a wake source, then wait for the restart or vector pulse;
  // source 2 drives nothing and leaves it to the periodic wake
  task automatic wake(input int src, output logic [3:0] got);
    int n;
    n = 0;
    got = 4'h0;
    @(posedge clk);
    case (src)
      0: wake_irq_pin_n <= 1'b0;
      1: keypad_interrupt_pins_n <= 8'hfe;
      3: reset_pin_n <= 1'b0;
      default: ;
    endcase
    while (got == 4'h0 && n < 1500)
    begin
      @(negedge clk);
      n++;
      if (por_restart === 1'b1 || vector_take === 1'b1)
        got = {por_restart, vector_take, vector_sel};
    end
  endtask

  // pins released and given time to pass the synchroniser before reuse
  task automatic settle();
    @(posedge clk);
    wake_irq_pin_n <= 1'b1;
    keypad_interrupt_pins_n <= 8'hff;
    reset_pin_n <= 1'b1;
    repeat (8) @(negedge clk);
    chk_mode(PMC_RUN);
  endtask

  initial
  begin
    logic [3:0] got;
    int k;
    do_reset(1'b0);
    chk_mode(PMC_HALT);
    chk("suspended", 32'h1, 32'(cpu_suspended));
    do_reset(1'b1);
    chk_mode(PMC_RUN);
    chk("clock enable", 32'h1, 32'(cpu_clock_en));
    wr(PMC_CTRL_OFS, 32'hffffffff);
    rdc(PMC_CTRL_OFS, 32'h3ff, "ctrl");
    wr(PMC_CTRL_OFS, 32'h0);
    wr(PMC_STAT_OFS, 32'hff);
    rdc(PMC_STAT_OFS, 32'h10, "status");
    rdc(4'hc, 32'h0, "unmapped");
    $display("test reset and registers done");
    for (k = 0; k < 8; k++)
      if (k != 3)
        cmd(3'(k), (k < 3) ? 3'b100 : 3'b001);
    cmd(PMC_CMD_HALT, 3'b100);
    chk_mode(PMC_HALT);
    chk("clock enable", 32'h0, 32'(cpu_clock_en));
    for (k = 0; k < 5; k++)
      cmd(3'(k), 3'b100);
    cmd(PMC_CMD_TRACE, 3'b100);
    chk("step", 32'h1, 32'(cpu_step));
    cmd(3'h7, 3'b001);
    cmd(PMC_CMD_GO, 3'b100);
    chk_mode(PMC_RUN);
    for (k = 2; k < 5; k++)
    begin
      stb(k);
      chk_mode(PMC_HALT);
      cmd(PMC_CMD_GO, 3'b100);
    end
    $display("test debug done");
    stb(0);
    chk("mask clear", 32'h1, 32'(imask_clear));
    chk_mode(PMC_WAIT);
    chk("clock enable", 32'h0, 32'(cpu_clock_en));
    cmd(PMC_CMD_MEMST, 3'b010);
    cmd(PMC_CMD_MEM, 3'b001);
    cmd(PMC_CMD_GO, 3'b001);
    @(posedge clk);
    irq_request <= 1'b1;
    @(posedge clk);
    irq_request <= 1'b0;
    @(negedge clk);
    chk("stacking", 32'h1, 32'(stack_start));
    chk_mode(PMC_RUN);
    stb(0);
    cmd(PMC_CMD_HALT, 3'b100);
    chk_mode(PMC_HALT);
    cmd(PMC_CMD_GO, 3'b100);
    stb(1);
    chk("illegal op", 32'h1, 32'(illegal_opcode_reset));
    chk_mode(PMC_RUN);
    $display("test wait done");
    enter(32'h3, PMC_STOP1);
    chk("ram, latch", 32'h0, {30'h0, ram_powered, pin_latch_hold});
    @(posedge clk);
    keypad_interrupt_pins_n <= 8'h00;
    repeat (12) @(negedge clk);
    chk_mode(PMC_STOP1);
    wake(0, got);
    chk("stop1 wake", 32'h2, 32'(got[3:2]));
    settle();
    rdc(PMC_CTRL_OFS, 32'h0, "ctrl after stop1");
    enter(32'h87, PMC_STOP2);
    chk("latch", 32'h1, 32'(pin_latch_hold));
    chk("periodic on", 32'h1, 32'(periodic_wake_on));
    wake(2, got);
    chk("stop2 wake", 32'h2, 32'(got[3:2]));
    settle();
    rdc(PMC_STAT_OFS, 32'h13, "status after stop2");
    rdc(PMC_CTRL_OFS, 32'h0, "ctrl after stop2");
    wr(PMC_ACK_OFS, 32'h1);
    rdc(PMC_STAT_OFS, 32'h10, "status after ack");
    $display("test stop1 and stop2 done");
    for (k = 0; k < 3; k++)
    begin
      enter(s3_ctrl[k], PMC_STOP3);
      chk("osc", 32'(k == 1), 32'(osc_run));
      wake(int'(s3_src[k]), got);
      chk("vector", {28'h0, 2'b01, s3_src[k]}, {28'h0, got});
      settle();
    end
    enter(32'h27, PMC_STOP3);
    cmd(PMC_CMD_MEMST, 3'b010);
    cmd(PMC_CMD_HALT, 3'b100);
    chk_mode(PMC_HALT);
    cmd(PMC_CMD_GO, 3'b100);
    enter(32'h1, PMC_STOP3);
    chk("periodic off", 32'h0, 32'(periodic_wake_on));
    repeat (300) @(negedge clk);
    chk_mode(PMC_STOP3);
    wake(3, got);
    chk("stop3 reset", 32'h2, 32'(got[3:2]));
    settle();
    rdc(PMC_CTRL_OFS, 32'h0, "ctrl after reset exit");
    $display("test stop3 done");
    final_report();
  end

  // the tests need some 700 cycles; cut a hang well beyond that
  initial
  begin
    #500000;
    chk("watchdog", 32'h0, 32'h1);
    final_report();
  end
endmodule

`default_nettype wire
